// ==== design/cbwa_pkg.sv ====
// Purpose: shared types and constants of the byte/word execution datapath
// Assumes: one cpu clock, synchronous active-high reset
// Notes: opcode codes 0..54 form the whole decodable repertoire
package cbwa_pkg;
	localparam int CBWA_NUM_INSTR = 55;
	localparam int CBWA_NUM_REGS = 8;
	localparam logic [2:0] CBWA_SP_IDX = 3'h7;
	localparam logic [7:0] CBWA_ABS8_PAGE = 8'hff;
	localparam logic [15:0] CBWA_STEP_BYTE = 16'h0001;
	localparam logic [15:0] CBWA_STEP_WORD = 16'h0002;
	localparam logic [3:0] CBWA_BCD_MAX = 4'h9;
	localparam logic [7:0] CBWA_BCD_HI_MAX = 8'h99;
	localparam logic [7:0] CBWA_ADJ_LO = 8'h06;
	localparam logic [7:0] CBWA_ADJ_HI = 8'h60;
	localparam logic [15:0] CBWA_GR_RST = 16'h0000;
	localparam logic [4:0] CBWA_FLAGS_RST = 5'h00;

	// datapath opcodes; codes from CBWA_OTHER_FIRST through 54 are executed elsewhere
	typedef enum logic [5:0] {
		CBWA_TRANSFER = 6'h00, CBWA_PUSH = 6'h01, CBWA_POP = 6'h02,
		CBWA_ADD = 6'h03, CBWA_SUB = 6'h04, CBWA_ADDC = 6'h05,
		CBWA_SUBC = 6'h06, CBWA_INC = 6'h07, CBWA_DECR = 6'h08,
		CBWA_PSTEP_UP = 6'h09, CBWA_PSTEP_DN = 6'h0a, CBWA_BCD_SUM = 6'h0b,
		CBWA_BCD_DIF = 6'h0c, CBWA_MUL = 6'h0d, CBWA_DIV = 6'h0e,
		CBWA_CMP = 6'h0f, CBWA_NEG = 6'h10, CBWA_AND = 6'h11,
		CBWA_OR = 6'h12, CBWA_XOR = 6'h13, CBWA_NOT = 6'h14,
		CBWA_ASL = 6'h15, CBWA_ASR = 6'h16, CBWA_LSL = 6'h17,
		CBWA_LSR = 6'h18, CBWA_ROL = 6'h19, CBWA_ROR = 6'h1a,
		CBWA_RCL = 6'h1b, CBWA_RCR = 6'h1c, CBWA_OTHER_FIRST = 6'h1d
	} cbwa_opc_t;

	// operand addressing modes
	typedef enum logic [2:0] {
		CBWA_AM_REG = 3'h0, CBWA_AM_IMM = 3'h1, CBWA_AM_IND = 3'h2,
		CBWA_AM_DISP = 3'h3, CBWA_AM_ABS16 = 3'h4, CBWA_AM_ABS8 = 3'h5,
		CBWA_AM_PREDEC = 3'h6, CBWA_AM_POSTINC = 3'h7
	} cbwa_amode_t;

	typedef enum logic [0:0] {
		CBWA_ST_IDLE = 1'b0,
		CBWA_ST_MEM = 1'b1
	} cbwa_state_t;

	// one decoded instruction; byte index 0..7 high halves, 8..15 low halves
	typedef struct packed {
		logic [5:0] opc;
		logic word;
		cbwa_amode_t amode;
		logic to_mem;
		logic step2;
		logic [3:0] rd;
		logic [3:0] rs;
		logic [15:0] imm;
	} cbwa_instr_t;

	typedef struct packed {
		logic h;
		logic n;
		logic z;
		logic v;
		logic c;
	} cbwa_flags_t;

	typedef struct packed {
		logic req;
		logic we;
		logic word;
		logic [15:0] addr;
		logic [15:0] wdata;
	} cbwa_mem_t;
endpackage : cbwa_pkg

// ==== design/cbwa_core.sv ====
// Purpose: execution datapath for byte and word transfer, arithmetic, logic and shifts
// Assumes: memory answers with mem_ack_in on the cpu clock, data valid with the ack
// Notes: general registers live here; other instruction groups are handed off

// What this block does
// - all 55 instruction codes decode; non-datapath groups are handed off.
// - transfer copies byte/word between registers, memory, or immediate into register.
// - short 8-bit absolute address works for byte transfers only.
// - push and pop decode as transfers; size, addressing mode and pointer register come from the instruction.
// - add takes register or immediate; subtract takes registers only.
// - word add and subtract need both operands in registers.
// - add/subtract with carry are byte-only and include the carry flag.
// - increment and decrement change a byte register by exactly one.
// - pointer steps are word-sized and change a register by one or two.
// - decimal adjust fixes a byte into two BCD digits using prior flags.
// - multiply two unsigned bytes into a sixteen-bit register.
// - divide sixteen by eight bits giving quotient and remainder bytes.
// - compare only sets flags; word compare needs two registers.
// - negate replaces a byte register with zero minus its value.
// - byte and, or, xor combine register with register or immediate.
// - invert replaces a byte register with its one's complement.
// - arithmetic shifts; right shift keeps the sign bit.
// - logical shifts fill the vacated bit with zero.
// - carry rotates go through carry; plain rotates stay in the byte.
// - overflow flag is one on arithmetic overflow, else zero; multiply, divide, pointer steps and decimal adjust leave it unchanged.
// - carry flag means borrow for subtracting operations.
// - odd word addresses are forced even.
module cbwa_core (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// instruction issue
	input wire logic op_valid_in,
	input wire cbwa_pkg::cbwa_instr_t op_in,
	output logic ready_out,
	output logic done_out,
	output logic pass_out,
	output logic illegal_out,
	// status and observation
	input wire logic [2:0] view_sel_in,
	output logic [15:0] view_out,
	output cbwa_pkg::cbwa_flags_t flags_out,
	// memory port
	output cbwa_pkg::cbwa_mem_t mem_out,
	input wire logic mem_ack_in,
	input wire logic [15:0] mem_rdata_in
);
	import cbwa_pkg::*;

	logic [15:0] gr_q [CBWA_NUM_REGS];
	cbwa_flags_t flags_q, flags_d;
	cbwa_state_t state_q;
	cbwa_instr_t ins_q;
	cbwa_mem_t mem_q;
	logic [15:0] ptr_q;
	logic ptr_upd_q;
	logic done_q, pass_q, illegal_q;
	logic [15:0] view_q;

	cbwa_opc_t opc;
	logic accept;
	logic [7:0] a8, b8, ax8, bx8, res8;
	logic [15:0] a16, b16, pbase, step, ea, ptr_new;
	logic cin, use_imm, is_sub;
	logic [8:0] add9, sub9;
	logic [4:0] add5, sub5;
	logic [16:0] add17, sub17;
	logic [12:0] add13, sub13;
	logic [7:0] adj8;
	logic [15:0] prod16;
	logic [15:0] quo16;
	logic [7:0] rem8;
	logic wr_en, wr_word, bad, is_mem, ptr_upd;
	logic [15:0] wr_val;

	// byte view of the register file
	function automatic logic [7:0] rbyte(input logic [15:0] w, input logic lo);
		rbyte = lo ? w[7:0] : w[15:8];
	endfunction : rbyte

	assign opc = cbwa_opc_t'(op_in.opc);
	assign accept = op_valid_in && (state_q == CBWA_ST_IDLE);
	assign use_imm = (op_in.amode == CBWA_AM_IMM);
	assign a16 = gr_q[op_in.rd[2:0]];
	assign b16 = use_imm ? op_in.imm : gr_q[op_in.rs[2:0]];
	assign a8 = rbyte(a16, op_in.rd[3]);
	assign b8 = use_imm ? op_in.imm[7:0] : rbyte(gr_q[op_in.rs[2:0]], op_in.rs[3]);

	// shared byte adder and subtractor; negate and inc/dec reuse them
	assign ax8 = (opc == CBWA_NEG) ? 8'h00 : a8;
	assign bx8 = (opc == CBWA_NEG) ? a8 : ((opc == CBWA_INC || opc == CBWA_DECR) ? 8'h01 : b8);
	assign cin = (opc == CBWA_ADDC || opc == CBWA_SUBC) ? flags_q.c : 1'b0;
	assign add9 = {1'b0, ax8} + {1'b0, bx8} + {8'h00, cin};
	assign sub9 = {1'b0, ax8} - {1'b0, bx8} - {8'h00, cin};
	assign add5 = {1'b0, ax8[3:0]} + {1'b0, bx8[3:0]} + {4'h0, cin};
	assign sub5 = {1'b0, ax8[3:0]} - {1'b0, bx8[3:0]} - {4'h0, cin};
	assign add17 = {1'b0, a16} + {1'b0, b16};
	assign sub17 = {1'b0, a16} - {1'b0, b16};
	assign add13 = {1'b0, a16[11:0]} + {1'b0, b16[11:0]};
	assign sub13 = {1'b0, a16[11:0]} - {1'b0, b16[11:0]};

	// unsigned multiply and divide; divisor zero leaves the register alone
	assign prod16 = {8'h00, a16[7:0]} * {8'h00, b8};
	assign quo16 = (b8 == 8'h00) ? 16'h0000 : a16 / {8'h00, b8};
	assign rem8 = (b8 == 8'h00) ? 8'h00 : 8'(a16 % {8'h00, b8});

	// memory address; stack forms use the chosen pointer register
	assign pbase = gr_q[op_in.rs[2:0]];
	assign step = op_in.word ? CBWA_STEP_WORD : CBWA_STEP_BYTE;
	always_comb begin
		case (op_in.amode)
			CBWA_AM_DISP: ea = pbase + op_in.imm;
			CBWA_AM_ABS16: ea = op_in.imm;
			CBWA_AM_ABS8: ea = {CBWA_ABS8_PAGE, op_in.imm[7:0]};
			CBWA_AM_PREDEC: ea = pbase - step;
			default: ea = pbase;
		endcase
		ptr_new = (op_in.amode == CBWA_AM_PREDEC) ? pbase - step : pbase + step;
		ptr_upd = (op_in.amode == CBWA_AM_PREDEC) || (op_in.amode == CBWA_AM_POSTINC);
	end

	// decimal adjust from the flags the previous operation left
	always_comb begin
		adj8 = 8'h00;
		if (opc == CBWA_BCD_SUM) begin
			if (flags_q.c || a8 > CBWA_BCD_HI_MAX) adj8 = adj8 | CBWA_ADJ_HI;
			if (flags_q.h || a8[3:0] > CBWA_BCD_MAX) adj8 = adj8 | CBWA_ADJ_LO;
		end else begin
			if (flags_q.c) adj8 = adj8 | CBWA_ADJ_HI;
			if (flags_q.h) adj8 = adj8 | CBWA_ADJ_LO;
		end
	end

	// operation decode and flag computation for the register forms
	always_comb begin
		flags_d = flags_q;
		wr_en = 1'b0;
		wr_word = 1'b0;
		wr_val = 16'h0000;
		res8 = 8'h00;
		bad = 1'b0;
		is_mem = 1'b0;
		is_sub = 1'b0;
		case (opc)
			CBWA_TRANSFER, CBWA_PUSH, CBWA_POP: begin
				if (op_in.amode == CBWA_AM_REG || use_imm) begin
					wr_en = 1'b1;
					wr_word = op_in.word;
					wr_val = op_in.word ? b16 : {8'h00, b8};
					flags_d.n = op_in.word ? b16[15] : b8[7];
					flags_d.z = op_in.word ? (b16 == 16'h0000) : (b8 == 8'h00);
					flags_d.v = 1'b0;
				end else begin
					is_mem = 1'b1;
					bad = op_in.word && (op_in.amode == CBWA_AM_ABS8);
				end
			end
			CBWA_ADD, CBWA_SUB, CBWA_CMP: begin
				is_sub = (opc != CBWA_ADD);
				bad = use_imm && ((opc == CBWA_SUB) || op_in.word);
				wr_en = (opc != CBWA_CMP);
				wr_word = op_in.word;
				if (op_in.word) begin
					wr_val = is_sub ? sub17[15:0] : add17[15:0];
					flags_d.c = is_sub ? sub17[16] : add17[16];
					flags_d.h = is_sub ? sub13[12] : add13[12];
					flags_d.n = wr_val[15];
					flags_d.z = (wr_val == 16'h0000);
					flags_d.v = is_sub ? (a16[15] != b16[15]) && (wr_val[15] != a16[15]) :
						(a16[15] == b16[15]) && (wr_val[15] != a16[15]);
				end else begin
					res8 = is_sub ? sub9[7:0] : add9[7:0];
					wr_val = {8'h00, res8};
					flags_d.c = is_sub ? sub9[8] : add9[8];
					flags_d.h = is_sub ? sub5[4] : add5[4];
					flags_d.n = res8[7];
					flags_d.z = (res8 == 8'h00);
					flags_d.v = is_sub ? (ax8[7] != bx8[7]) && (res8[7] != ax8[7]) :
						(ax8[7] == bx8[7]) && (res8[7] != ax8[7]);
				end
			end
			CBWA_ADDC, CBWA_SUBC, CBWA_NEG: begin
				is_sub = (opc != CBWA_ADDC);
				bad = op_in.word;
				res8 = is_sub ? sub9[7:0] : add9[7:0];
				wr_en = 1'b1;
				wr_val = {8'h00, res8};
				flags_d.c = is_sub ? sub9[8] : add9[8];
				flags_d.h = is_sub ? sub5[4] : add5[4];
				flags_d.n = res8[7];
				// chained forms only clear zero, so a multi-byte zero test survives
				flags_d.z = (opc == CBWA_NEG) ? (res8 == 8'h00) : (flags_q.z && res8 == 8'h00);
				flags_d.v = is_sub ? (ax8[7] != bx8[7]) && (res8[7] != ax8[7]) :
					(ax8[7] == bx8[7]) && (res8[7] != ax8[7]);
			end
			CBWA_INC, CBWA_DECR: begin
				res8 = (opc == CBWA_INC) ? add9[7:0] : sub9[7:0];
				bad = op_in.word;
				wr_en = 1'b1;
				wr_val = {8'h00, res8};
				flags_d.n = res8[7];
				flags_d.z = (res8 == 8'h00);
				flags_d.v = (opc == CBWA_INC) ? (a8 == 8'h7f) : (a8 == 8'h80);
			end
			CBWA_PSTEP_UP, CBWA_PSTEP_DN: begin
				wr_en = 1'b1;
				wr_word = 1'b1;
				wr_val = (opc == CBWA_PSTEP_UP) ?
					a16 + (op_in.step2 ? CBWA_STEP_WORD : CBWA_STEP_BYTE) :
					a16 - (op_in.step2 ? CBWA_STEP_WORD : CBWA_STEP_BYTE);
			end
			CBWA_BCD_SUM, CBWA_BCD_DIF: begin
				res8 = (opc == CBWA_BCD_SUM) ? a8 + adj8 : a8 - adj8;
				wr_en = 1'b1;
				wr_val = {8'h00, res8};
				if (opc == CBWA_BCD_SUM) flags_d.c = flags_q.c || adj8[6];
				flags_d.n = res8[7];
				flags_d.z = (res8 == 8'h00);
			end
			CBWA_MUL: begin
				wr_en = 1'b1;
				wr_word = 1'b1;
				wr_val = prod16;
			end
			CBWA_DIV: begin
				wr_en = (b8 != 8'h00);
				wr_word = 1'b1;
				wr_val = {rem8, quo16[7:0]};
				flags_d.n = b8[7];
				flags_d.z = (b8 == 8'h00);
			end
			CBWA_AND, CBWA_OR, CBWA_XOR, CBWA_NOT: begin
				case (opc)
					CBWA_AND: res8 = a8 & b8;
					CBWA_OR: res8 = a8 | b8;
					CBWA_XOR: res8 = a8 ^ b8;
					default: res8 = ~a8;
				endcase
				wr_en = 1'b1;
				wr_val = {8'h00, res8};
				flags_d.n = res8[7];
				flags_d.z = (res8 == 8'h00);
				flags_d.v = 1'b0;
			end
			CBWA_ASL, CBWA_ASR, CBWA_LSL, CBWA_LSR, CBWA_ROL, CBWA_ROR, CBWA_RCL, CBWA_RCR:
			begin
				case (opc)
					CBWA_ASL, CBWA_LSL: res8 = {a8[6:0], 1'b0};
					CBWA_ASR: res8 = {a8[7], a8[7:1]};
					CBWA_LSR: res8 = {1'b0, a8[7:1]};
					CBWA_ROL: res8 = {a8[6:0], a8[7]};
					CBWA_ROR: res8 = {a8[0], a8[7:1]};
					CBWA_RCL: res8 = {a8[6:0], flags_q.c};
					default: res8 = {flags_q.c, a8[7:1]};
				endcase
				wr_en = 1'b1;
				wr_val = {8'h00, res8};
				flags_d.c = (opc == CBWA_ASL || opc == CBWA_LSL || opc == CBWA_ROL ||
					opc == CBWA_RCL) ? a8[7] : a8[0];
				flags_d.n = res8[7];
				flags_d.z = (res8 == 8'h00);
				flags_d.v = (opc == CBWA_ASL) ? (a8[7] ^ a8[6]) : 1'b0;
			end
			default: begin
				bad = (op_in.opc >= 6'(CBWA_NUM_INSTR));
			end
		endcase
	end

	// sequencing: register forms finish in one cycle, memory forms wait for the ack
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			state_q <= CBWA_ST_IDLE;
			ins_q <= '0;
			ptr_q <= 16'h0000;
			ptr_upd_q <= 1'b0;
		end else begin
			case (state_q)
				CBWA_ST_IDLE: begin
					if (accept && is_mem && !bad) begin
						state_q <= CBWA_ST_MEM;
						ins_q <= op_in;
						ptr_q <= ptr_new;
						ptr_upd_q <= ptr_upd;
					end
				end
				CBWA_ST_MEM: begin
					if (mem_ack_in) state_q <= CBWA_ST_IDLE;
				end
				default: state_q <= CBWA_ST_IDLE;
			endcase
		end
	end

	// memory request, held until the ack; word addresses are forced even
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			mem_q <= '0;
		end else if (accept && is_mem && !bad) begin
			mem_q.req <= 1'b1;
			mem_q.we <= op_in.to_mem;
			mem_q.word <= op_in.word;
			mem_q.addr <= op_in.word ? {ea[15:1], 1'b0} : ea;
			mem_q.wdata <= op_in.word ? a16 : {8'h00, a8};
		end else if (mem_ack_in) begin
			mem_q.req <= 1'b0;
		end
	end

	// register file: pointer update first so a pop into the pointer keeps the loaded data
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < CBWA_NUM_REGS; i++) gr_q[i] <= CBWA_GR_RST;
		end else if (state_q == CBWA_ST_MEM && mem_ack_in) begin
			if (ptr_upd_q) gr_q[ins_q.rs[2:0]] <= ptr_q;
			if (!ins_q.to_mem && ins_q.word) gr_q[ins_q.rd[2:0]] <= mem_rdata_in;
			else if (!ins_q.to_mem && ins_q.rd[3]) gr_q[ins_q.rd[2:0]][7:0] <= mem_rdata_in[7:0];
			else if (!ins_q.to_mem) gr_q[ins_q.rd[2:0]][15:8] <= mem_rdata_in[7:0];
		end else if (accept && wr_en && !bad) begin
			if (wr_word) gr_q[op_in.rd[2:0]] <= wr_val;
			else if (op_in.rd[3]) gr_q[op_in.rd[2:0]][7:0] <= wr_val[7:0];
			else gr_q[op_in.rd[2:0]][15:8] <= wr_val[7:0];
		end
	end

	// flags: memory transfers take n and z from the data moved and clear v
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			flags_q <= CBWA_FLAGS_RST;
		end else if (state_q == CBWA_ST_MEM && mem_ack_in) begin
			flags_q.v <= 1'b0;
			if (ins_q.to_mem) begin
				flags_q.n <= ins_q.word ? mem_q.wdata[15] : mem_q.wdata[7];
				flags_q.z <= ins_q.word ? (mem_q.wdata == 16'h0000) : (mem_q.wdata[7:0] == 8'h00);
			end else begin
				flags_q.n <= ins_q.word ? mem_rdata_in[15] : mem_rdata_in[7];
				flags_q.z <= ins_q.word ? (mem_rdata_in == 16'h0000) :
					(mem_rdata_in[7:0] == 8'h00);
			end
		end else if (accept && !is_mem && !bad) begin
			flags_q <= flags_d;
		end
	end

	// completion strobes, one cycle each
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			done_q <= 1'b0;
			pass_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			done_q <= (accept && !is_mem && !bad && op_in.opc < CBWA_OTHER_FIRST) ||
				(state_q == CBWA_ST_MEM && mem_ack_in);
			pass_q <= accept && (op_in.opc >= CBWA_OTHER_FIRST) && !bad;
			illegal_q <= accept && bad;
		end
	end

	// observation register; one cycle behind the file
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) view_q <= 16'h0000;
		else view_q <= gr_q[view_sel_in];
	end

	assign ready_out = (state_q == CBWA_ST_IDLE);
	assign done_out = done_q;
	assign pass_out = pass_q;
	assign illegal_out = illegal_q;
	assign view_out = view_q;
	assign flags_out = flags_q;
	assign mem_out = mem_q;
endmodule : cbwa_core

// ==== tb/cbwa_core_checker.sv ====
// Purpose: port-level assertions on the datapath core
// Assumes: one cpu clock, synchronous active-high reset
// Notes: bound to every cbwa_core instance below
module cbwa_core_checker (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// instruction issue
	input wire logic op_valid_in,
	input wire cbwa_pkg::cbwa_instr_t op_in,
	input wire logic ready_out,
	input wire logic done_out,
	input wire logic pass_out,
	input wire logic illegal_out,
	// status and observation
	input wire logic [2:0] view_sel_in,
	input wire logic [15:0] view_out,
	input wire cbwa_pkg::cbwa_flags_t flags_out,
	// memory port
	input wire cbwa_pkg::cbwa_mem_t mem_out,
	input wire logic mem_ack_in,
	input wire logic [15:0] mem_rdata_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import cbwa_pkg::*;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	// an accepted instruction, and the refusal that must follow it
	sequence s_take;
		op_valid_in && ready_out;
	endsequence
	sequence s_refuse;
		##1 illegal_out && !done_out;
	endsequence
	AST_OPC_RANGE: assert property (s_take ##0 op_in.opc >= 6'h37 |-> s_refuse)
		else $error("opcode beyond repertoire not refused");
	AST_PASS_OFF: assert property (s_take ##0 (op_in.opc >= 6'h1d && op_in.opc < 6'h37)
		|-> ##1 pass_out && !done_out) else $error("other group not handed off");
	AST_SUB_IMM: assert property (s_take ##0
		(op_in.opc == CBWA_SUB && op_in.amode == CBWA_AM_IMM) |-> s_refuse)
		else $error("immediate subtract not refused");
	AST_WORD_IMM: assert property (s_take ##0 (op_in.word && op_in.amode == CBWA_AM_IMM
		&& op_in.opc inside {CBWA_ADD, CBWA_CMP}) |-> s_refuse) else $error("word imm taken");
	AST_BYTE_ONLY: assert property (s_take ##0
		(op_in.word && op_in.opc inside {CBWA_ADDC, CBWA_SUBC}) |-> s_refuse)
		else $error("word carry op not refused");
	AST_ABS8_WORD: assert property (s_take ##0 (op_in.opc == CBWA_TRANSFER
		&& op_in.word && op_in.amode == CBWA_AM_ABS8) |-> s_refuse) else $error("word abs8 taken");
	AST_REFUSE_KEEP: assert property (illegal_out |-> $stable(flags_out))
		else $error("refused form changed flags");
	AST_EVEN_ADDR: assert property (mem_out.req && mem_out.word |-> !mem_out.addr[0])
		else $error("odd word address issued");
	AST_REQ_HOLD: assert property (mem_out.req && !mem_ack_in
		|=> mem_out.req && $stable(mem_out.addr) && !ready_out) else $error("request dropped");
	AST_MEM_END: assert property (mem_out.req && mem_ack_in
		|=> done_out && !mem_out.req && ready_out) else $error("access did not close");
	AST_PUSH_FORM: assert property (s_take ##0 (op_in.opc == CBWA_PUSH && op_in.word)
		|-> ##1 mem_out.req && mem_out.we && mem_out.word) else $error("push not a word store");
endmodule : cbwa_core_checker

bind cbwa_core cbwa_core_checker cbwa_core_checker_inst (.clock_in(clock_in),
	.sys_rst_in(sys_rst_in), .op_valid_in(op_valid_in), .op_in(op_in), .ready_out(ready_out),
	.done_out(done_out), .pass_out(pass_out), .illegal_out(illegal_out),
	.view_sel_in(view_sel_in), .view_out(view_out), .flags_out(flags_out),
	.mem_out(mem_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in));

// ==== tb/cbwa_core_tb.sv ====
// Purpose: self-checking bench for the datapath core against an integer model
// Assumes: inputs change on the falling edge, outputs read there too
// Notes: flag compares are masked where the model does not predict a bit
module cbwa_core_tb import cbwa_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic op_valid_in = 1'b0;
	cbwa_instr_t op_in = '0;
	logic [2:0] view_sel_in = 3'h0;
	logic mem_ack_in = 1'b0;
	logic [15:0] mem_rdata_in = 16'h0000;
	logic ready_out, done_out, pass_out, illegal_out;
	logic [15:0] view_out;
	cbwa_flags_t flags_out;
	cbwa_mem_t mem_out;
	logic [15:0] egr [8];
	logic [4:0] ef;
	int err_total = 0;
	int cmp_count = 0;
	int seed = 32'h0775;
	int cyc = 0;
	cbwa_opc_t tbl [24] = '{CBWA_ADD, CBWA_SUB, CBWA_ADDC, CBWA_SUBC, CBWA_INC, CBWA_DECR,
		CBWA_NEG, CBWA_AND, CBWA_OR, CBWA_XOR, CBWA_NOT, CBWA_ASL, CBWA_ASR, CBWA_LSL, CBWA_LSR,
		CBWA_ROL, CBWA_ROR, CBWA_RCL, CBWA_RCR, CBWA_CMP, CBWA_MUL, CBWA_DIV, CBWA_PSTEP_UP,
		CBWA_PSTEP_DN};

	cbwa_core cbwa_core_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.op_valid_in(op_valid_in), .op_in(op_in), .ready_out(ready_out), .done_out(done_out),
		.pass_out(pass_out), .illegal_out(illegal_out), .view_sel_in(view_sel_in),
		.view_out(view_out), .flags_out(flags_out), .mem_out(mem_out),
		.mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in));

	// 10 MHz cpu clock
	initial begin
		forever #50 clock_in = ~clock_in;
	end

	// hang guard, about four times the expected run
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (err_total == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	function automatic cbwa_instr_t mk(input logic [5:0] o, input logic w, input cbwa_amode_t a,
		input logic [3:0] d, input logic [3:0] s, input logic [15:0] v, input logic t);
		return {o, w, a, t, 1'b0, d, s, v};
	endfunction : mk

	// byte index: bit 3 clear picks the high half
	function automatic int rb(input logic [3:0] x);
		return x[3] ? egr[x[2:0]][7:0] : egr[x[2:0]][15:8];
	endfunction : rb

	// integer reference of one register-form instruction; fm says which flags it predicts
	task automatic model(input cbwa_instr_t i, output logic [4:0] fm);
		int a, b, r, m, sb, ci, hm;
		bit fl, wr;
		m = i.word ? 32'hffff : 32'hff;
		sb = i.word ? 32'h8000 : 32'h80;
		hm = i.word ? 32'hfff : 32'hf;
		a = i.word ? int'(egr[i.rd[2:0]]) : rb(i.rd);
		b = (i.amode == CBWA_AM_IMM) ? (i.imm & m) : i.word ? int'(egr[i.rs[2:0]]) : rb(i.rs);
		ci = ef[0];
		fl = 1'b1;
		wr = 1'b1;
		fm = 5'h0f;
		r = 0;
		ef[1] = 1'b0;
		case (i.opc)
			CBWA_TRANSFER: r = b;
			CBWA_ADD, CBWA_ADDC: begin
				r = a + b + ((i.opc == CBWA_ADDC) ? ci : 0);
				ef[0] = r > m;
				ef[1] = ((~(a ^ b)) & (a ^ r) & sb) != 0;
				ef[4] = ((a & hm) + (b & hm) + ((i.opc == CBWA_ADDC) ? ci : 0)) > hm;
				fm = 5'h1f;
			end
			CBWA_SUB, CBWA_SUBC, CBWA_CMP: begin
				r = a - b - ((i.opc == CBWA_SUBC) ? ci : 0);
				ef[0] = r < 0;
				ef[1] = ((a ^ b) & (a ^ r) & sb) != 0;
				ef[4] = ((a & hm) - (b & hm) - ((i.opc == CBWA_SUBC) ? ci : 0)) < 0;
				fm = 5'h1f;
				wr = i.opc != CBWA_CMP;
			end
			CBWA_INC, CBWA_DECR: begin
				r = (i.opc == CBWA_INC) ? a + 1 : a - 1;
				ef[1] = a == ((i.opc == CBWA_INC) ? 32'h7f : 32'h80);
			end
			CBWA_NEG: begin
				r = -a;
				ef[1] = a == 32'h80;
				ef[0] = a != 0;
			end
			CBWA_AND: r = a & b;
			CBWA_OR: r = a | b;
			CBWA_XOR: r = a ^ b;
			CBWA_NOT: r = ~a;
			CBWA_ASL, CBWA_LSL, CBWA_ROL, CBWA_RCL: begin
				r = (a << 1) | ((i.opc == CBWA_ROL) ? (a >> 7) : (i.opc == CBWA_RCL) ? ci : 0);
				ef[0] = a[7];
				ef[1] = (i.opc == CBWA_ASL) && (a[7] ^ a[6]);
			end
			CBWA_ASR, CBWA_LSR, CBWA_ROR, CBWA_RCR: begin
				r = (a >> 1) | ((i.opc == CBWA_ASR) ? (a & 32'h80) : (i.opc == CBWA_ROR) ?
					((a & 1) << 7) : (i.opc == CBWA_RCR) ? (ci << 7) : 0);
				ef[0] = a[0];
			end
			CBWA_MUL, CBWA_PSTEP_UP, CBWA_PSTEP_DN: begin
				fl = 1'b0;
				fm = 5'h05;
				if (i.opc == CBWA_MUL) egr[i.rd[2:0]] = 16'(egr[i.rd[2:0]][7:0] * b);
				else if (i.opc == CBWA_PSTEP_UP) egr[i.rd[2:0]] += i.step2 ? 16'h0002 : 16'h0001;
				else egr[i.rd[2:0]] -= i.step2 ? 16'h0002 : 16'h0001;
			end
			CBWA_DIV: begin
				a = egr[i.rd[2:0]];
				fl = 1'b0;
				fm = 5'h05;
				ef[2] = b == 0;
				// an oversized quotient keeps only its low byte
				if (b != 0) egr[i.rd[2:0]] = 16'(((a % b) << 8) | ((a / b) & 255));
			end
			default: begin
				fl = 1'b0;
				fm = 5'h00;
			end
		endcase
		if (fl) begin
			r = r & m;
			ef[2] = (i.opc inside {CBWA_ADDC, CBWA_SUBC}) ? ef[2] && (r == 0) : (r == 0);
			ef[3] = (r & sb) != 0;
			if (wr && i.word) egr[i.rd[2:0]] = 16'(r);
			else if (wr && i.rd[3]) egr[i.rd[2:0]][7:0] = 8'(r);
			else if (wr) egr[i.rd[2:0]][15:8] = 8'(r);
		end
	endtask : model

	// kind 0 done, 1 refused, 2 handed off; a refused form must leave the register alone
	task automatic do_op(input cbwa_instr_t i, input int kind);
		logic [4:0] fm;
		fm = 5'h1f;
		if (kind == 0) model(i, fm);
		@(negedge clock_in);
		op_valid_in = 1'b1;
		op_in = i;
		@(negedge clock_in);
		op_valid_in = 1'b0;
		view_sel_in = i.rd[2:0];
		chk({13'h0000, done_out, illegal_out, pass_out}, 16'h0004 >> kind);
		@(negedge clock_in);
		chk(view_out, egr[i.rd[2:0]]);
		chk({11'h000, flags_out & fm}, {11'h000, ef & fm});
	endtask : do_op

	// memory form with a one-cycle stall before the answer
	task automatic mem_op(input cbwa_instr_t i, input logic [15:0] ea, input logic [15:0] ewd,
		input logic [15:0] wm, input logic [15:0] d, input logic [2:0] sel);
		int k;
		@(negedge clock_in);
		op_valid_in = 1'b1;
		op_in = i;
		@(negedge clock_in);
		op_valid_in = 1'b0;
		view_sel_in = sel;
		for (k = 0; k < 20 && mem_out.req !== 1'b1; k++) @(negedge clock_in);
		@(negedge clock_in);
		chk(mem_out.addr, ea);
		chk(mem_out.wdata & wm, ewd & wm);
		chk({15'h0000, mem_out.we}, {15'h0000, i.to_mem});
		mem_ack_in = 1'b1;
		mem_rdata_in = d;
		@(negedge clock_in);
		mem_ack_in = 1'b0;
		mem_rdata_in = ~d;
		chk({15'h0000, done_out}, 16'h0001);
		// a transfer sets n and z from the data moved and clears v
		ef[1] = 1'b0;
		ef[2] = i.to_mem ? ((ewd & wm) == 16'h0000) : i.word ? (d == 16'h0000) : (d[7:0] == 8'h00);
		ef[3] = i.to_mem ? (i.word ? ewd[15] : ewd[7]) : (i.word ? d[15] : d[7]);
		chk({11'h000, flags_out & 5'h0e}, {11'h000, ef & 5'h0e});
		@(negedge clock_in);
	endtask : mem_op

	// main sequence
	initial begin
		cbwa_instr_t i;
		logic [15:0] d;
		int n;
		repeat (6) @(negedge clock_in);
		sys_rst_in = 1'b0;
		chk({10'h000, ready_out, flags_out}, 16'h0020);
		ef = 5'h00;
		for (n = 0; n < 8; n++) begin
			d = (n == 0) ? 16'h0000 : (n == 1) ? 16'h1235 : 16'($random(seed)) & 16'hfffe;
			do_op(mk(CBWA_TRANSFER, 1'b1, CBWA_AM_IMM, 4'(n), 4'h0, d, 1'b0), 0);
		end
		do_op(mk(CBWA_SUB, 1'b0, CBWA_AM_IMM, 4'h9, 4'h0, 16'h0011, 1'b0), 1);
		do_op(mk(CBWA_ADD, 1'b1, CBWA_AM_IMM, 4'h1, 4'h0, 16'h0011, 1'b0), 1);
		do_op(mk(CBWA_CMP, 1'b1, CBWA_AM_IMM, 4'h1, 4'h0, 16'h0011, 1'b0), 1);
		do_op(mk(CBWA_ADDC, 1'b1, CBWA_AM_REG, 4'h1, 4'h2, 16'h0000, 1'b0), 1);
		do_op(mk(CBWA_NEG, 1'b1, CBWA_AM_REG, 4'h1, 4'h0, 16'h0000, 1'b0), 1);
		do_op(mk(CBWA_TRANSFER, 1'b1, CBWA_AM_ABS8, 4'h1, 4'h0, 16'h0040, 1'b0), 1);
		do_op(mk(6'h37, 1'b0, CBWA_AM_REG, 4'h1, 4'h0, 16'h0000, 1'b0), 1);
		do_op(mk(6'h1d, 1'b0, CBWA_AM_REG, 4'h1, 4'h0, 16'h0000, 1'b0), 2);
		do_op(mk(6'h36, 1'b0, CBWA_AM_REG, 4'h1, 4'h0, 16'h0000, 1'b0), 2);
		do_op(mk(CBWA_DIV, 1'b0, CBWA_AM_REG, 4'h1, 4'h0, 16'h0000, 1'b0), 0);
		do_op(mk(CBWA_TRANSFER, 1'b0, CBWA_AM_IMM, 4'hc, 4'h0, 16'h0015, 1'b0), 0);
		do_op(mk(CBWA_ADD, 1'b0, CBWA_AM_IMM, 4'hc, 4'h0, 16'h0027, 1'b0), 0);
		egr[4][7:0] = 8'h42;
		do_op(mk(CBWA_BCD_SUM, 1'b0, CBWA_AM_REG, 4'hc, 4'h0, 16'h0000, 1'b0), 0);
		do_op(mk(CBWA_TRANSFER, 1'b0, CBWA_AM_IMM, 4'hd, 4'h0, 16'h0015, 1'b0), 0);
		do_op(mk(CBWA_SUB, 1'b0, CBWA_AM_REG, 4'hc, 4'hd, 16'h0000, 1'b0), 0);
		egr[4][7:0] = 8'h27;
		do_op(mk(CBWA_BCD_DIF, 1'b0, CBWA_AM_REG, 4'hc, 4'h0, 16'h0000, 1'b0), 0);
		d = 16'($random(seed));
		mem_op(mk(CBWA_TRANSFER, 1'b1, CBWA_AM_IND, 4'h2, 4'h1, 16'h0000, 1'b0), 16'h1234,
			16'h0000, 16'h0000, d, 3'h2);
		egr[2] = d;
		chk(view_out, egr[2]);
		mem_op(mk(CBWA_PUSH, 1'b1, CBWA_AM_PREDEC, 4'h2, 4'h7, 16'h0000, 1'b1), egr[7] - 16'h0002,
			egr[2], 16'hffff, d, 3'h7);
		egr[7] -= 16'h0002;
		chk(view_out, egr[7]);
		d = 16'($random(seed));
		mem_op(mk(CBWA_POP, 1'b1, CBWA_AM_POSTINC, 4'h3, 4'h7, 16'h0000, 1'b0), egr[7],
			16'h0000, 16'h0000, d, 3'h3);
		egr[3] = d;
		egr[7] += 16'h0002;
		chk(view_out, egr[3]);
		mem_op(mk(CBWA_TRANSFER, 1'b0, CBWA_AM_ABS8, 4'h9, 4'h0, 16'h0040, 1'b1), 16'hff40,
			{8'h00, egr[1][7:0]}, 16'h00ff, d, 3'h1);
		// random register forms; word size only where a word form exists
		for (n = 0; n < 300; n++) begin
			i = mk(tbl[$unsigned($random(seed)) % 24], 1'b0, CBWA_AM_REG, 4'($random(seed)),
				4'($random(seed)), 16'($random(seed)), 1'b0);
			i.step2 = 1'($random(seed));
			if (i.opc inside {CBWA_ADD, CBWA_ADDC, CBWA_SUBC, CBWA_AND, CBWA_OR, CBWA_XOR, CBWA_CMP}
				&& i.step2) i.amode = CBWA_AM_IMM;
			else if (i.opc inside {CBWA_ADD, CBWA_SUB, CBWA_CMP} && i.imm[0]) i.word = 1'b1;
			if (i.opc inside {CBWA_PSTEP_UP, CBWA_PSTEP_DN}) i.word = 1'b1;
			if (i.word || i.opc inside {CBWA_MUL, CBWA_DIV}) i.rd[3] = 1'b0;
			do_op(i, 0);
		end
		stop_test();
	end
endmodule : cbwa_core_tb
